// *** hdl/prb_pkg.sv ***
// Purpose: Shared constants and types for the paged register bank.
// Assumes: 16-bit command frames, 8-bit registers, two register pages.
// Notes: Masks give the writable bits; all other bits read as zero.
package prb_pkg;
   // ==========================================================
   // Frame layout
   // ==========================================================
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] CNT_HDR_LAST = 5'h07;  // Falling edge index of the R/W bit
   localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;  // Falling edge index of the last bit
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 9;
   localparam int RW_BIT = 8;

   // ==========================================================
   // Page 0 offsets
   // ==========================================================
   localparam logic [6:0] OFS_DEVICE_RESET = 7'h01;
   localparam logic [6:0] OFS_MANUAL = 7'h04;
   localparam logic [6:0] OFS_AUTO = 7'h05;
   localparam logic [6:0] OFS_AUX = 7'h06;
   localparam logic [6:0] OFS_SCAN = 7'h0C;
   localparam logic [6:0] OFS_RANGE01 = 7'h10;
   localparam logic [6:0] OFS_RANGE23 = 7'h11;
   localparam logic [6:0] OFS_RANGE45 = 7'h12;
   localparam logic [6:0] OFS_RANGE67 = 7'h13;
   localparam logic [6:0] OFS_TEMP_FLAGS = 7'h20;
   localparam logic [6:0] OFS_TRIP_LO = 7'h21;
   localparam logic [6:0] OFS_LIVE_LO = 7'h22;
   localparam logic [6:0] OFS_TRIP_HI = 7'h23;
   localparam logic [6:0] OFS_LIVE_HI = 7'h24;
   localparam logic [6:0] OFS_PAGE = 7'h7F;
   localparam logic [7:0] PAGE1_SELECT = 8'h01;

   // ==========================================================
   // Reset values and writable masks
   // ==========================================================
   localparam logic [7:0] RST_MANUAL = 8'h00;
   localparam logic [7:0] RST_AUTO = 8'h00;
   localparam logic [7:0] RST_AUX = 8'h08;
   localparam logic [7:0] RST_SCAN = 8'h00;
   localparam logic [7:0] RST_RANGE = 8'h11;
   localparam logic [7:0] RST_THR = 8'h00;
   localparam logic RST_SEQ_AUTO = 1'b0;
   localparam logic [7:0] MASK_MANUAL = 8'h7F;
   localparam logic [7:0] MASK_AUTO = 8'h0F;  // Sequence restart bit is a command, not stored
   localparam logic [7:0] MASK_AUX = 8'h0E;
   localparam logic [7:0] MASK_RANGE = 8'h77;
   localparam int AUTO_RESTART_BIT = 7;
   localparam int DEVICE_RESET_BIT = 0;
   localparam int AUX_ALARM_PIN_POWER_CONTROL_BIT = 3;

   // ==========================================================
   // Page 1 threshold storage
   // ==========================================================
   localparam int THR_COUNT = 36;
   localparam logic [6:0] THR_LAST = 7'h23;
   typedef logic [THR_COUNT-1:0][7:0] prb_thr_type;
   typedef enum {PRB_IDLE, PRB_SHIFT, PRB_DONE} prb_state_type;
endpackage

// *** hdl/prb_sync.sv ***
// Purpose: Two-flop synchroniser for the serial link pins.
// Assumes: Inputs are asynchronous to core_clk_in.
// Notes: The first stage feeds only the second stage.
module prb_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Pins and synchronised levels
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // ==========================================================
   // Two stages, both reset to the idle level
   // ==========================================================
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q <= pins_in;
         sync_out <= meta_q;
      end
   end
endmodule // prb_sync

// *** hdl/prb_bank.sv ***
// Purpose: Paged register bank behind a four-wire serial command link.
// Assumes: Link pins are asynchronous and much slower than core_clk_in.
// Notes: Pin edges are found by oversampling; no second clock domain.
// Overview of operation
// RL1: After reset the active page is page 0.
// RL2: On page 0, reads and writes decode against page 0 registers only.
// RL3: Writing 01h to address 7Fh selects page 1 for later accesses.
// RL4: Page 0 holds sequencing commands, configuration and alarm flag reads.
// RL5: Page 1 holds alarm thresholds for each channel and the temperature sensor.
// RL6: An all-zero frame changes nothing; the last sequencing mode stays.
// RL7: All registers on both pages return to defaults at reset.
// RL8: Alarm flag registers are read-only and follow alarm evaluation.
// RL9: Command word: address bits 15..9, write flag bit 8, data bits 7..0.
// RL10: A read shifts the addressed byte out over the last eight clocks.
// RL11: Writes apply at next chip-select fall; power-down applies at 16th fall.
// RL12: The host gives at least 16 serial clocks per frame.
// RL13: Writing one to device reset bit resets all registers; bit reads zero.
// RL14: Fixed-zero bits read zero whatever the host writes.
module prb_bank (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Serial link pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   // Alarm evaluation results, same clock domain
   input wire logic [3:0] temp_flags_in,
   input wire logic [7:0] trip_lo_in,
   input wire logic [7:0] live_lo_in,
   input wire logic [7:0] trip_hi_in,
   input wire logic [7:0] live_hi_in,
   // Register contents toward the converter
   output logic page_out,
   output logic seq_auto_out,
   output logic seq_restart_out,
   output logic [7:0] manual_cmd_out,
   output logic [7:0] auto_cmd_out,
   output logic [7:0] aux_config_out,
   output logic [7:0] scan_enable_out,
   output logic [31:0] range_out,
   output prb_pkg::prb_thr_type thr_out
);
   import prb_pkg::*;

   logic sclk_s, cs_n_s, din_s, cs_prev_q, sclk_prev_q, cs_fall, cs_rise, sclk_fall;
   prb_state_type state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] shift_q, shift_d, word;
   logic [7:0] out_sh_q, out_sh_d, rd_byte;
   logic dout_d, dout_oe_d, page_d, seq_auto_d, seq_restart_d;
   logic [7:0] manual_d, auto_d, aux_d, scan_d;
   logic [31:0] range_d;
   prb_thr_type thr_d;
   logic pend_valid_q, pend_valid_d, pend_page_q, pend_page_d, zero_frame;
   logic [6:0] pend_addr_q, pend_addr_d;
   logic [7:0] pend_data_q, pend_data_d;
   logic [6:0] hdr_addr;

   // ==========================================================
   // Pin synchronisers; chip select idles high
   // ==========================================================
   prb_sync #(.WIDTH(3), .RESET_VAL(3'h4)) i_prb_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .pins_in({cs_n_in, sclk_in, din_in}),
      .sync_out({cs_n_s, sclk_s, din_s})
   );

   // Edge detection on the synchronised levels
   assign cs_fall = cs_prev_q & ~cs_n_s;
   assign cs_rise = ~cs_prev_q & cs_n_s;
   assign sclk_fall = sclk_prev_q & ~sclk_s & ~cs_n_s;
   assign hdr_addr = shift_q[6:0];  // Address once seven bits are in
   assign word = {shift_q[14:0], din_s};
   assign zero_frame = state_q == PRB_SHIFT && sclk_fall && cnt_q == CNT_FRAME_LAST
      && word == 16'h0000;

   // ==========================================================
   // Read decode for the header just received
   // ==========================================================
   always_comb begin
      rd_byte = 8'h00;  // Unmapped addresses read zero
      if (hdr_addr == OFS_PAGE) begin
         rd_byte = {7'h00, page_out};
      end else if (page_out) begin
         if (hdr_addr <= THR_LAST) rd_byte = thr_out[hdr_addr];  // see RL5
      end else begin
         unique case (hdr_addr)  // see RL2, see RL4
            OFS_MANUAL: rd_byte = manual_cmd_out;
            OFS_AUTO: rd_byte = auto_cmd_out;
            OFS_AUX: rd_byte = aux_config_out;
            OFS_SCAN: rd_byte = scan_enable_out;
            OFS_RANGE01: rd_byte = range_out[31:24];
            OFS_RANGE23: rd_byte = range_out[23:16];
            OFS_RANGE45: rd_byte = range_out[15:8];
            OFS_RANGE67: rd_byte = range_out[7:0];
            OFS_TEMP_FLAGS: rd_byte = {temp_flags_in, 4'h0};  // Same clock, no sync, see RL8
            OFS_TRIP_LO: rd_byte = trip_lo_in;  // see RL8
            OFS_LIVE_LO: rd_byte = live_lo_in;
            OFS_TRIP_HI: rd_byte = trip_hi_in;
            OFS_LIVE_HI: rd_byte = live_hi_in;
            default: rd_byte = 8'h00;  // Device reset bit always reads zero, see RL13
         endcase
      end
   end

   // ==========================================================
   // Frame engine and register next values
   // ==========================================================
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      out_sh_d = out_sh_q;
      dout_d = dout_out;
      dout_oe_d = dout_oe_out;
      page_d = page_out;
      seq_auto_d = seq_auto_out;
      seq_restart_d = 1'b0;
      manual_d = manual_cmd_out;
      auto_d = auto_cmd_out;
      aux_d = aux_config_out;
      scan_d = scan_enable_out;
      range_d = range_out;
      thr_d = thr_out;
      pend_valid_d = pend_valid_q;
      pend_page_d = pend_page_q;
      pend_addr_d = pend_addr_q;
      pend_data_d = pend_data_q;
      if (cs_rise) begin
         // Frame abandoned or ended; an unfinished command is dropped
         state_d = PRB_IDLE;
         dout_oe_d = 1'b0;
         dout_d = 1'b0;
      end else if (cs_fall) begin
         state_d = PRB_SHIFT;
         cnt_d = 5'h00;
         dout_oe_d = 1'b1;
         dout_d = 1'b0;
         pend_valid_d = 1'b0;
         if (pend_valid_q) begin  // see RL11
            if (!pend_page_q && pend_addr_q == OFS_DEVICE_RESET
                  && pend_data_q[DEVICE_RESET_BIT]) begin
               // Full register reset, both pages, see RL7, see RL13
               page_d = 1'b0;
               seq_auto_d = RST_SEQ_AUTO;
               manual_d = RST_MANUAL;
               auto_d = RST_AUTO;
               aux_d = RST_AUX;
               scan_d = RST_SCAN;
               range_d = {4{RST_RANGE}};
               thr_d = {THR_COUNT{RST_THR}};
            end else if (pend_addr_q == OFS_PAGE) begin
               page_d = pend_data_q == PAGE1_SELECT;  // see RL3
            end else if (pend_page_q) begin
               if (pend_addr_q <= THR_LAST) thr_d[pend_addr_q] = pend_data_q;  // see RL5
            end else begin
               unique case (pend_addr_q)  // see RL2, see RL14
                  OFS_MANUAL: begin
                     manual_d = pend_data_q & MASK_MANUAL;
                     seq_auto_d = 1'b0;
                  end
                  OFS_AUTO: begin
                     auto_d = pend_data_q & MASK_AUTO;
                     seq_auto_d = 1'b1;
                     seq_restart_d = pend_data_q[AUTO_RESTART_BIT];
                  end
                  OFS_SCAN: scan_d = pend_data_q;
                  OFS_RANGE01: range_d[31:24] = pend_data_q & MASK_RANGE;
                  OFS_RANGE23: range_d[23:16] = pend_data_q & MASK_RANGE;
                  OFS_RANGE45: range_d[15:8] = pend_data_q & MASK_RANGE;
                  OFS_RANGE67: range_d[7:0] = pend_data_q & MASK_RANGE;
                  default: ;  // Flag registers and unmapped: write ignored, see RL8
               endcase
            end
         end
      end else if (state_q == PRB_SHIFT && sclk_fall) begin
         // Input bit taken on each falling edge, MSB first, see RL9
         shift_d = word;
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == CNT_HDR_LAST) begin
            if (!din_s) begin  // Read: load addressed byte, see RL10
               out_sh_d = rd_byte;
               dout_d = rd_byte[7];
            end
         end else if (cnt_q > CNT_HDR_LAST && cnt_q < CNT_FRAME_LAST) begin
            out_sh_d = {out_sh_q[6:0], 1'b0};
            dout_d = out_sh_q[6];
         end
         if (cnt_q == CNT_FRAME_LAST) begin
            state_d = PRB_DONE;
            dout_oe_d = 1'b0;
            dout_d = 1'b0;
            if (word[RW_BIT]) begin
               if (!page_out && word[ADDR_MSB:ADDR_LSB] == OFS_AUX) begin
                  aux_d = word[7:0] & MASK_AUX;  // Power-down acts at 16th edge, see RL11
               end else begin
                  pend_valid_d = 1'b1;  // Held until next chip-select fall, see RL11
                  pend_page_d = page_out;
                  pend_addr_d = word[ADDR_MSB:ADDR_LSB];
                  pend_data_d = word[7:0];
               end
            end
            // All-zero word is a read of address zero: no state change, see RL6
         end
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
         state_q <= PRB_IDLE;
         cnt_q <= 5'h00;
         shift_q <= 16'h0000;
         out_sh_q <= 8'h00;
         dout_out <= 1'b0;
         dout_oe_out <= 1'b0;
         page_out <= 1'b0;  // see RL1
         seq_auto_out <= RST_SEQ_AUTO;
         seq_restart_out <= 1'b0;
         manual_cmd_out <= RST_MANUAL;
         auto_cmd_out <= RST_AUTO;
         aux_config_out <= RST_AUX;
         scan_enable_out <= RST_SCAN;
         range_out <= {4{RST_RANGE}};
         thr_out <= {THR_COUNT{RST_THR}};
         pend_valid_q <= 1'b0;
         pend_page_q <= 1'b0;
         pend_addr_q <= 7'h00;
         pend_data_q <= 8'h00;
      end else begin
         cs_prev_q <= cs_n_s;
         sclk_prev_q <= sclk_s;
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         out_sh_q <= out_sh_d;
         dout_out <= dout_d;
         dout_oe_out <= dout_oe_d;
         page_out <= page_d;
         seq_auto_out <= seq_auto_d;
         seq_restart_out <= seq_restart_d;
         manual_cmd_out <= manual_d;
         auto_cmd_out <= auto_d;
         aux_config_out <= aux_d;
         scan_enable_out <= scan_d;
         range_out <= range_d;
         thr_out <= thr_d;
         pend_valid_q <= pend_valid_d;
         pend_page_q <= pend_page_d;
         pend_addr_q <= pend_addr_d;
         pend_data_q <= pend_data_d;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   a_page_after_reset: assert property ($past(rst_in) |-> !page_out)  // see RL1
      else $error("page not zero after reset");
   a_page_select: assert property (cs_fall && pend_valid_q && pend_addr_q == OFS_PAGE
      && pend_data_q == PAGE1_SELECT |=> page_out)  // see RL3
      else $error("page 1 not selected");
   a_page0_thr_safe: assert property (cs_fall && pend_valid_q && !pend_page_q
      && pend_addr_q != OFS_DEVICE_RESET |=> thr_out == $past(thr_out))  // see RL2
      else $error("page 0 write changed threshold");
   a_thr_written: assert property (cs_fall && pend_valid_q && pend_page_q
      && pend_addr_q <= THR_LAST |=> thr_out[$past(pend_addr_q)] == $past(pend_data_q))  // see RL5
      else $error("threshold write lost");
   a_zero_frame: assert property (zero_frame
      |=> !pend_valid_q && $stable(seq_auto_out) && $stable(aux_config_out))  // see RL6
      else $error("zero frame changed state");
   a_device_reset: assert property (cs_fall && pend_valid_q && !pend_page_q
      && pend_addr_q == OFS_DEVICE_RESET && pend_data_q[0]
      |=> aux_config_out == RST_AUX && range_out == {4{RST_RANGE}} && !page_out)  // see RL13
      else $error("device reset incomplete");
   a_flag_readback: assert property (state_q == PRB_SHIFT && sclk_fall && cnt_q == CNT_HDR_LAST
      && !din_s && !page_out && hdr_addr == OFS_TRIP_LO |=> dout_out == $past(trip_lo_in[7]))  // see RL8
      else $error("flag byte not shifted out");
   a_read_shift: assert property (state_q == PRB_SHIFT && sclk_fall && cnt_q == CNT_HDR_LAST
      && !din_s |=> dout_oe_out && dout_out == $past(rd_byte[7]))  // see RL10
      else $error("read data not driven");
   a_write_deferred: assert property (pend_valid_q && !cs_fall |=> $stable(manual_cmd_out)
      && $stable(scan_enable_out) && $stable(range_out))  // see RL11
      else $error("write applied before chip-select fall");
   a_fixed_zero: assert property ((aux_config_out & ~MASK_AUX) == 8'h00
      && (range_out & ~{4{MASK_RANGE}}) == 32'h0 && manual_cmd_out[7] == 1'b0)  // see RL14
      else $error("fixed-zero bit set");
endmodule // prb_bank

// *** sim/prb_host.sv ***
// Purpose: Host-side model of the four-wire serial command link.
// Assumes: Pin changes follow core clock edges; link clock period 800 ns.
// Notes: Link clock stands low between frames; short frames only on request.
module prb_host (
   // Clock
   input wire logic core_clk_in,
   // Link pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out,
   input wire logic dout_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // ========
   // Idle levels
   // ========
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end

   // ========
   // One frame, MSB first; data in changes as the link clock rises, and once more at chip-select release
   // ========
   task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge core_clk_in);
      cs_n_out <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      for (int i = 0; i < nbits; i++) begin
         sclk_out <= 1'b1;
         din_out <= word[15-i];
         repeat (4) @(posedge core_clk_in);
         // Sample late in the high phase, well after the device shifted
         if (i >= 8) begin
            rd = {rd[6:0], dout_in};
         end
         sclk_out <= 1'b0;
         repeat (4) @(posedge core_clk_in);
      end
      cs_n_out <= 1'b1;
      din_out <= ~din_out;  // A released line must not hold its last level
      repeat (6) @(posedge core_clk_in);
   endtask
endmodule  // prb_host

// *** sim/tb_prb_bank.sv ***
// Purpose: Self-checking bench for the paged register bank.
// Assumes: Host model drives the link; alarm flags driven on core clock.
// Notes: Writes other than to the aux register land at the next frame, so a read also applies a write.
module tb_prb_bank;
   timeunit 1ns;
   timeprecision 1ns;
   import prb_pkg::*;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, din, dout, dout_oe, page, seq_auto, seq_restart;
   logic dout_pin;
   logic [3:0] temp_flags = 4'h0;
   logic [7:0] trip_lo = 8'h00, live_lo = 8'h00, trip_hi = 8'h00, live_hi = 8'h00;
   logic [7:0] manual_cmd, auto_cmd, aux_cfg, scan_en;
   logic [31:0] range_v;
   prb_thr_type thr;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int pulses = 0;
   // Page 0 map: offset, reset value, writable mask
   logic [6:0] map_a [10] = '{7'h01, 7'h04, 7'h05, 7'h06, 7'h0C, 7'h10, 7'h11, 7'h12, 7'h13,
                              7'h7F};
   logic [7:0] map_r [10] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h11, 8'h11, 8'h11, 8'h11,
                              8'h00};
   logic [7:0] map_m [10] = '{8'h00, 8'h7F, 8'h0F, 8'h0E, 8'hFF, 8'h77, 8'h77, 8'h77, 8'h77,
                              8'h00};
   logic [7:0] flag_x [5] = '{8'hA0, 8'h5A, 8'hC3, 8'h81, 8'h3C};

   // ========
   // Clock, design and host
   // ========
   always #50 core_clk = ~core_clk;

   // Released pin shows the inverse of the data output, which is zeroed on release, so it reads high: no pull resistor is assumed
   assign dout_pin = dout_oe ? dout : ~dout;

   prb_bank i_prb_bank (
      .core_clk_in(core_clk), .rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
      .dout_out(dout), .dout_oe_out(dout_oe), .temp_flags_in(temp_flags),
      .trip_lo_in(trip_lo), .live_lo_in(live_lo), .trip_hi_in(trip_hi),
      .live_hi_in(live_hi), .page_out(page), .seq_auto_out(seq_auto),
      .seq_restart_out(seq_restart), .manual_cmd_out(manual_cmd), .auto_cmd_out(auto_cmd),
      .aux_config_out(aux_cfg), .scan_enable_out(scan_en), .range_out(range_v),
      .thr_out(thr)
   );

   prb_host i_prb_host (
      .core_clk_in(core_clk), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
      .dout_in(dout_pin)
   );

   // ========
   // Checking and reporting
   // ========
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tend(input string name);
      $display("test %s done", name);
   endtask

   // Register access over the link
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      i_prb_host.frame({a, 1'b1, d}, 16, r);
   endtask

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
      logic [7:0] r;
      i_prb_host.frame({a, 1'b0, 8'h00}, 16, r);
      chk({24'h0, r}, {24'h0, exp}, what);
   endtask

   // Whole page 0 map and port view against reset values
   task automatic defaults();
      for (int i = 0; i < 10; i++) begin
         rchk(map_a[i], map_r[i], "default value");
      end
      chk({31'h0, page}, 32'h0, "page after reset");
      chk({31'h0, seq_auto}, 32'h0, "mode after reset");
      chk(range_v, 32'h11111111, "range port");
      chk({31'h0, thr === '0}, 32'h1, "thresholds cleared");
   endtask

   // Restart pulses and a cycle ceiling well above about 10000 expected cycles
   always @(posedge core_clk) begin
      cycles++;
      if (seq_restart === 1'b1) begin
         pulses++;
      end
      if (cycles == 40000) begin
         err_count++;
         $display("[ERR] %0t run did not finish", $time);
         final_report();
      end
   end

   // ========
   // Main sequence
   // ========
   initial begin
      logic [7:0] r;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      defaults();
      tend("defaults");
      // All ones into each writable page 0 register; fixed bits must stay zero
      for (int i = 1; i < 9; i++) begin
         wr(map_a[i], 8'hFF);
         rchk(map_a[i], map_m[i], "masked readback");
      end
      chk(pulses, 1, "restart pulse");
      tend("masks");
      // Commit points, short frame, unmapped place
      wr(7'h10, 8'h25);
      chk(range_v[31:24], 8'h77, "range before commit");
      rchk(7'h10, 8'h25, "range after commit");
      chk(range_v[31:24], 8'h25, "range port");
      wr(7'h06, 8'h02);
      chk(aux_cfg, 8'h02, "power control at last fall");
      i_prb_host.frame({7'h10, 1'b1, 8'h00}, 10, r);
      rchk(7'h10, 8'h25, "short frame dropped");
      rchk(7'h30, 8'h00, "unmapped read");
      chk({31'h0, dout_oe}, 32'h0, "output released");
      tend("commit");
      // Mode set by a write, then kept through all-zero frames
      for (int m = 0; m < 2; m++) begin
         wr(m ? 7'h05 : 7'h04, 8'h01);
         repeat (2) i_prb_host.frame(16'h0000, 16, r);
         chk({31'h0, seq_auto}, m, "mode kept");
      end
      tend("modes");
      // Flags follow the inputs and ignore writes
      temp_flags <= 4'hA;
      trip_lo <= 8'h5A;
      live_lo <= 8'hC3;
      trip_hi <= 8'h81;
      live_hi <= 8'h3C;
      for (int i = 0; i < 5; i++) begin
         wr(7'h20 + 7'(i), ~flag_x[i]);
         rchk(7'h20 + 7'(i), flag_x[i], "flag readback");
      end
      tend("flags");
      // Threshold page; its low bytes are not the reset register
      wr(7'h7F, 8'h01);
      rchk(7'h7F, 8'h01, "page register");
      chk({31'h0, page}, 32'h1, "page port");
      wr(7'h05, 8'hA5);
      wr(7'h23, 8'h3C);
      wr(7'h24, 8'h77);
      wr(7'h01, 8'h01);
      rchk(7'h05, 8'hA5, "threshold byte");
      rchk(7'h23, 8'h3C, "last threshold");
      rchk(7'h24, 8'h00, "beyond thresholds");
      rchk(7'h01, 8'h01, "threshold not reset bit");
      chk(thr[5], 8'hA5, "threshold port");
      wr(7'h7F, 8'h00);
      rchk(7'h05, 8'h01, "back on page 0");
      tend("pages");
      // Device reset by command restores both pages
      wr(7'h01, 8'h01);
      defaults();
      tend("device reset");
      final_report();
   end
endmodule  // tb_prb_bank
